// ---- rtl/sai_regs.svh ----
`ifndef SAI_REGS_SVH
`define SAI_REGS_SVH
// How it works
// - Format field selects I2S, LJ, RJ, TDM
// - Word length from format bits 1:0
// - Offset is format bit7 plus offset byte
// - Short TDM frame sync needs bits 3:2=01; the device ignores bits 3:2
// - MSB first two's complement, up to 32
// - Reset gives I2S with 24-bit words
// - Bad bit-clock ratio raises clock error
// - Sample rate class detected automatically
// - Internal timing derived from bit clock
// - Clock stop puts processing to sleep
// - Clock halt: outputs Hi-Z, error flagged
// - Clocks back: resume previous state
// - Host halts clocks 100 us on rate change
// - Data shifted in on bit clock
// - Word clock is channel select or sync
// - Frame sync high one bit; rising starts
// - I2S: left low, right high
// - Right-justified: left high, right low

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is index times four), then byte addresses
`define SAI_IDX_FORMAT     12'h033
`define SAI_IDX_OFFSET     12'h034
`define SAI_IDX_STATUS     12'h071
`define SAI_ADDR_CTRL      12'h200
`define SAI_ADDR_ISTAT     12'h204
`define SAI_ADDR_IEN       12'h208
`define SAI_ADDR_ICLR      12'h20C

////////////////////////////////////////////////////////////////////////////////
// Fields and reset values
`define SAI_FORMAT_RESET   8'h02
`define SAI_OFFSET_RESET   8'h00
`define SAI_CTRL_RESET     1'b1
`define SAI_RESP_OKAY      2'h0
`define SAI_RESP_SLVERR    2'h2

////////////////////////////////////////////////////////////////////////////////
// Timing
`define SAI_CLK_MHZ        10
`define SAI_HALT_NS        4000
`define SAI_HALT_CYC       ((`SAI_HALT_NS * `SAI_CLK_MHZ + 999) / 1000)
`define SAI_RATE_B32_NS    27000
`define SAI_RATE_B48_NS    15000
`define SAI_RATE_B96_NS    7800
`define SAI_RATE_B32_CYC   (`SAI_RATE_B32_NS * `SAI_CLK_MHZ / 1000)
`define SAI_RATE_B48_CYC   (`SAI_RATE_B48_NS * `SAI_CLK_MHZ / 1000)
`define SAI_RATE_B96_CYC   (`SAI_RATE_B96_NS * `SAI_CLK_MHZ / 1000)
`define SAI_HOST_DIV       4
`endif

// ---- rtl/sai_pkg.sv ----
package sai_pkg;
   typedef enum logic [1:0] {
      SAI_FMT_I2S = 2'b00,
      SAI_FMT_LJ  = 2'b01,
      SAI_FMT_RJ  = 2'b10,
      SAI_FMT_TDM = 2'b11
   } sai_fmt_t;

   typedef enum logic {
      SAI_PLAY  = 1'b0,
      SAI_SLEEP = 1'b1
   } sai_mode_t;

   typedef struct packed {
      logic [2:0]  s1;
      logic [2:0]  s2;
      logic        sclk_last;
      logic        lr_last;
      logic [9:0]  cnt;
      logic [9:0]  half;
      logic [9:0]  fcnt;
      logic [11:0] pcnt;
      logic [7:0]  idle;
      logic [31:0] sh;
      logic [31:0] left;
      logic [31:0] right;
      logic        valid;
      logic [7:0]  fmt;
      logic [7:0]  off;
      logic        play;
      logic        ratio_err;
      logic        halted;
      logic [1:0]  rate;
      sai_mode_t   mode;
      logic        hiz;
      logic        sleep;
      logic [2:0]  ist;
      logic [2:0]  ien;
      logic        irq;
      logic        aw_got;
      logic [11:0] aw_addr;
      logic        w_got;
      logic [7:0]  wbyte;
      logic        wstb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sai_dev_state_t;

   typedef struct packed {
      logic [7:0]  div;
      logic        sclk;
      logic [9:0]  pos;
      logic        lr;
      logic        dat;
      logic [31:0] lbuf;
      logic [31:0] rbuf;
      logic        taken;
   } sai_host_state_t;

   // Word length code to bit count
   function automatic logic [9:0] sai_wl_bits(input logic [1:0] code);
      logic [9:0] n;
      n = 10'h010;
      case (code)
         2'h0: n = 10'h010;
         2'h1: n = 10'h014;
         2'h2: n = 10'h018;
         default: n = 10'h020;
      endcase
      return n;
   endfunction
endpackage

// ---- rtl/sai_link_if.sv ----
`timescale 1ns/100ps
interface sai_link_if;
   logic bit_clock;
   logic word_clock_frame_sync;
   logic serial_audio_data_in;

   modport host
   (
      output bit_clock,
      output word_clock_frame_sync,
      output serial_audio_data_in
   );

   modport device
   (
      input bit_clock,
      input word_clock_frame_sync,
      input serial_audio_data_in
   );
endinterface

// ---- rtl/sai_device.sv ----
`timescale 1ns/100ps
`include "sai_regs.svh"
module sai_device #(
   parameter int HALT_CYC = `SAI_HALT_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   sai_link_if.device       link,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [31:0] left_sample,
   output      logic [31:0] right_sample,
   output      logic        sample_valid,
   output      logic [1:0]  rate_code,
   output      logic        amp_hiz,
   output      logic        dsp_sleep,
   output      logic        irq
);
   sai_pkg::sai_dev_state_t q;
   sai_pkg::sai_dev_state_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // Rate class from core cycles per frame
   function automatic logic [1:0] rate_class(input logic [11:0] p);
      logic [1:0] r;
      r = 2'h3;
      if (p >= 12'(`SAI_RATE_B32_CYC))
         r = 2'h0;
      else if (p >= 12'(`SAI_RATE_B48_CYC))
         r = 2'h1;
      else if (p >= 12'(`SAI_RATE_B96_CYC))
         r = 2'h2;
      return r;
   endfunction

   // Bit clocks per frame allowed for format and rate
   function automatic logic ratio_ok(input sai_pkg::sai_fmt_t f, input logic [1:0] r,
                                     input logic [9:0] n);
      logic ok;
      ok = 1'b0;
      if (f != sai_pkg::SAI_FMT_TDM)
         ok = (n == 10'h020) || (n == 10'h040);
      else
         ok = (n == 10'h080) || ((n == 10'h100) && (r == 2'h1 || r == 2'h2)) ||
              ((n == 10'h200) && (r == 2'h1));
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic              rise;
      logic              lr_edge;
      logic              fstart;
      logic              restart;
      logic              rgt;
      logic              wrap;
      logic [9:0]        hc;
      logic              legal;
      logic              halt_now;
      logic [9:0]        h;
      logic [9:0]        start;
      logic [9:0]        wl;
      logic [9:0]        offs;
      logic [1:0]        rc;
      logic [2:0]        clr;
      logic [2:0]        ev;
      logic [31:0]       word;
      sai_pkg::sai_fmt_t fmt;
      d        = q;
      d.valid  = 1'b0;
      clr      = 3'h0;
      fmt      = sai_pkg::sai_fmt_t'(q.fmt[5:4]);
      wl       = sai_pkg::sai_wl_bits(q.fmt[1:0]);
      offs     = {1'b0, q.fmt[7], q.off};
      d.s1     = {link.serial_audio_data_in, link.word_clock_frame_sync, link.bit_clock};
      d.s2     = q.s1;
      d.sclk_last = q.s2[0];
      rise     = q.s2[0] & ~q.sclk_last;
      lr_edge  = rise & (q.s2[1] != q.lr_last);
      fstart   = lr_edge & (q.s2[1] ^ (fmt == sai_pkg::SAI_FMT_I2S));
      restart  = (fmt == sai_pkg::SAI_FMT_TDM) ? fstart : lr_edge;
      h        = restart ? 10'h000 : ((q.cnt == 10'h3FF) ? q.cnt : q.cnt + 10'h001);
      wrap     = restart & (fmt == sai_pkg::SAI_FMT_I2S);
      hc       = wrap ? q.cnt + 10'h001 : h;
      rgt      = (fmt == sai_pkg::SAI_FMT_TDM) ? (h >= offs + wl)
                 : (q.s2[1] ^ (fmt != sai_pkg::SAI_FMT_I2S) ^ wrap);
      start    = offs;
      case (fmt)
         sai_pkg::SAI_FMT_I2S: start = offs + 10'h001;
         sai_pkg::SAI_FMT_LJ:  start = offs;
         sai_pkg::SAI_FMT_RJ:  start = q.half - wl;
         default:              start = rgt ? offs + wl : offs;
      endcase
      word     = {q.sh[30:0], q.s2[2]} << (10'h020 - wl);
      rc       = rate_class(q.pcnt);
      legal    = ratio_ok(fmt, rc, q.fcnt + 10'h001);
      halt_now = q.idle >= 8'(HALT_CYC);

      ////////////////////////////////////////////////////////////////////////////////
      // Serial capture
      if (rise)
      begin
         d.lr_last = q.s2[1];
         d.cnt     = h;
         if (restart)
            d.half = q.cnt + 10'h001;
         if (hc >= start && hc < start + wl)
         begin
            d.sh = {q.sh[30:0], q.s2[2]};
            if (hc == start + wl - 10'h001)
            begin
               if (rgt)
               begin
                  d.right = word;
                  d.valid = 1'b1;
               end
               else
                  d.left = word;
            end
         end
      end

      ////////////////////////////////////////////////////////////////////////////////
      // Clock supervision
      d.idle = rise ? 8'h00 : ((q.idle == 8'hFF) ? q.idle : q.idle + 8'h01);
      d.halted = halt_now;
      if (halt_now)
      begin
         d.fcnt = 10'h000;
         d.pcnt = 12'h000;
      end
      else
      begin
         d.pcnt = (q.pcnt == 12'hFFF) ? q.pcnt : q.pcnt + 12'h001;
         if (fstart)
         begin
            d.fcnt      = 10'h000;
            d.pcnt      = 12'h000;
            d.ratio_err = ~legal;
            d.rate      = rc;
         end
         else if (rise)
         begin
            d.fcnt = (q.fcnt == 10'h3FF) ? q.fcnt : q.fcnt + 10'h001;
            if (q.fcnt == 10'h3FF)
               d.ratio_err = 1'b1;
         end
      end
      unique case (q.mode)
         sai_pkg::SAI_PLAY:
            if (halt_now)
               d.mode = sai_pkg::SAI_SLEEP;
         sai_pkg::SAI_SLEEP:
            if (fstart & legal & ~halt_now)
               d.mode = sai_pkg::SAI_PLAY;
      endcase

      ////////////////////////////////////////////////////////////////////////////////
      // AXI4-Lite slave
      if (q.bvalid & s_axi_bready)
         d.bvalid = 1'b0;
      if (s_axi_awvalid & q.awready)
      begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid & q.wready)
      begin
         d.w_got = 1'b1;
         d.wbyte = s_axi_wdata[7:0];
         d.wstb  = s_axi_wstrb[0];
      end
      if (q.aw_got & q.w_got & ~q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `SAI_RESP_OKAY;
         case (q.aw_addr)
            (`SAI_IDX_FORMAT << 2): if (q.wstb) d.fmt = q.wbyte;
            (`SAI_IDX_OFFSET << 2): if (q.wstb) d.off = q.wbyte;
            `SAI_ADDR_CTRL:         if (q.wstb) d.play = q.wbyte[0];
            `SAI_ADDR_IEN:          if (q.wstb) d.ien = q.wbyte[2:0];
            `SAI_ADDR_ICLR:         if (q.wstb) clr = q.wbyte[2:0];
            default:                d.bresp = `SAI_RESP_SLVERR;
         endcase
      end
      if (q.rvalid & s_axi_rready)
         d.rvalid = 1'b0;
      if (s_axi_arvalid & q.arready)
      begin
         d.rvalid = 1'b1;
         d.rresp  = `SAI_RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            (`SAI_IDX_FORMAT << 2): d.rdata[7:0] = q.fmt;
            (`SAI_IDX_OFFSET << 2): d.rdata[7:0] = q.off;
            (`SAI_IDX_STATUS << 2): d.rdata[3:0] = {q.rate, q.halted,
                                                    q.ratio_err | q.halted};
            `SAI_ADDR_CTRL:         d.rdata[0] = q.play;
            `SAI_ADDR_ISTAT:        d.rdata[2:0] = q.ist;
            `SAI_ADDR_IEN:          d.rdata[2:0] = q.ien;
            `SAI_ADDR_ICLR:         d.rdata = 32'h0000_0000;
            default:                d.rresp = `SAI_RESP_SLVERR;
         endcase
      end
      d.awready = ~d.aw_got & ~d.bvalid;
      d.wready  = ~d.w_got & ~d.bvalid;
      d.arready = ~d.rvalid;

      ////////////////////////////////////////////////////////////////////////////////
      // Outputs and interrupts
      d.hiz   = (d.mode == sai_pkg::SAI_SLEEP) | ~d.play;
      d.sleep = d.mode == sai_pkg::SAI_SLEEP;
      ev      = {(d.mode == sai_pkg::SAI_PLAY) & (q.mode == sai_pkg::SAI_SLEEP),
                 d.halted & ~q.halted, d.ratio_err & ~q.ratio_err};
      d.ist   = (q.ist & ~clr) | ev;
      d.irq   = |(d.ist & d.ien);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q       <= '0;
         q.fmt   <= `SAI_FORMAT_RESET;
         q.off   <= `SAI_OFFSET_RESET;
         q.play  <= `SAI_CTRL_RESET;
         q.mode  <= sai_pkg::SAI_SLEEP;
         q.hiz   <= 1'b1;
         q.sleep <= 1'b1;
      end
      else
         q <= d;
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rvalid  = q.rvalid;
   assign left_sample   = q.left;
   assign right_sample  = q.right;
   assign sample_valid  = q.valid;
   assign rate_code     = q.rate;
   assign amp_hiz       = q.hiz;
   assign dsp_sleep     = q.sleep;
   assign irq           = q.irq;
endmodule

// ---- rtl/sai_host.sv ----
`timescale 1ns/100ps
`include "sai_regs.svh"
module sai_host #(
   parameter int DIV = `SAI_HOST_DIV
)(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   sai_link_if.host         link,
   input  wire logic [1:0]  fmt,
   input  wire logic [1:0]  wl_code,
   input  wire logic [8:0]  offset,
   input  wire logic [9:0]  frame_bits,
   input  wire logic        run,
   input  wire logic [31:0] left_in,
   input  wire logic [31:0] right_in,
   output      logic        sample_taken
);
   sai_pkg::sai_host_state_t q;
   sai_pkg::sai_host_state_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // Bit clock divider and frame sequencer
   always_comb
   begin
      logic [9:0]  p;
      logic [9:0]  pl;
      logic [9:0]  hb;
      logic [9:0]  hpos;
      logic [9:0]  wl;
      logic [9:0]  offs;
      logic [9:0]  start;
      logic [9:0]  idx;
      logic        rgt;
      logic [31:0] word;
      sai_pkg::sai_fmt_t f;
      d       = q;
      d.taken = 1'b0;
      word    = 32'h0000_0000;
      f       = sai_pkg::sai_fmt_t'(fmt);
      wl      = sai_pkg::sai_wl_bits(wl_code);
      offs    = {1'b0, offset};
      hb      = frame_bits >> 1;
      p       = (q.pos >= frame_bits - 10'h001) ? 10'h000 : q.pos + 10'h001;
      pl      = (p == 10'h000) ? frame_bits - 10'h001 : p - 10'h001;
      pl      = (f == sai_pkg::SAI_FMT_I2S) ? pl : p;
      hpos    = (f == sai_pkg::SAI_FMT_TDM || pl < hb) ? pl : pl - hb;
      rgt     = (f == sai_pkg::SAI_FMT_TDM) ? (hpos >= offs + wl) : (pl >= hb);
      start   = offs;
      case (f)
         sai_pkg::SAI_FMT_I2S: start = offs;
         sai_pkg::SAI_FMT_LJ:  start = offs;
         sai_pkg::SAI_FMT_RJ:  start = hb - wl;
         default:              start = rgt ? offs + wl : offs;
      endcase
      idx     = 10'h01F - (hpos - start);
      if (!run && !q.sclk)
      begin
         d.div  = 8'h00;
         d.sclk = 1'b0;
         d.pos  = frame_bits - 10'h001;
         d.lr   = 1'b0;
         d.dat  = 1'b0;
      end
      else if (q.div >= 8'(DIV - 1))
      begin
         d.div  = 8'h00;
         d.sclk = ~q.sclk;
         if (q.sclk)
         begin
            d.pos = p;
            if (pl == 10'h000)
            begin
               d.lbuf  = left_in;
               d.rbuf  = right_in;
               d.taken = 1'b1;
            end
            word = rgt ? d.rbuf : d.lbuf;
            case (f)
               sai_pkg::SAI_FMT_I2S: d.lr = p >= hb;
               sai_pkg::SAI_FMT_TDM: d.lr = p == 10'h000;
               default:              d.lr = p < hb;
            endcase
            d.dat = (hpos >= start && hpos < start + wl) ? word[idx[4:0]] : 1'b0;
         end
      end
      else
         d.div = q.div + 8'h01;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         q <= '0;
      else
         q <= d;
   end

   assign link.bit_clock             = q.sclk;
   assign link.word_clock_frame_sync = q.lr;
   assign link.serial_audio_data_in  = q.dat;
   assign sample_taken               = q.taken;
endmodule

// ---- verif/sai_link_props.sv ----
`timescale 1ns/100ps
module sai_link_props #(
   parameter int HALT_CYC = 40
)(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic bit_clock,
   input wire logic word_clock_frame_sync,
   input wire logic serial_audio_data_in,
   input wire logic sample_valid,
   input wire logic amp_hiz,
   input wire logic dsp_sleep,
   input wire logic sample_taken
);
   logic [7:0] quiet_q;
   logic [7:0] quiet_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Core cycles since bit clock was last high
   always_comb
   begin
      quiet_d = quiet_q;
      if (bit_clock)
         quiet_d = 8'h00;
      else if (quiet_q != 8'hFF)
         quiet_d = quiet_q + 8'h01;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         quiet_q <= 8'h00;
      else
         quiet_q <= quiet_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link and device checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_bclk_high_width: assert property ($rose(bit_clock) |=> $stable(bit_clock)[*3])
      else $error("bit clock high phase too short");
   a_bclk_low_width: assert property ($fell(bit_clock) |=> $stable(bit_clock)[*3])
      else $error("bit clock low phase too short");
   a_sync_on_low: assert property ($changed(word_clock_frame_sync) |-> !bit_clock)
      else $error("word clock moved while bit clock high");
   a_data_on_low: assert property ($changed(serial_audio_data_in) |-> !bit_clock)
      else $error("data moved while bit clock high");
   a_sync_held_high: assert property ($rose(bit_clock) |=>
                                      $stable(word_clock_frame_sync)[*3])
      else $error("word clock not held across sampling");
   a_halt_to_sleep: assert property (quiet_q == 8'(HALT_CYC + 10) |-> dsp_sleep && amp_hiz)
      else $error("no sleep after clock halt");
   a_sleep_means_hiz: assert property (dsp_sleep |-> amp_hiz)
      else $error("outputs driven while asleep");
   a_valid_pulse: assert property (sample_valid |=> !sample_valid)
      else $error("sample valid longer than one cycle");
   a_valid_live_clock: assert property (sample_valid |-> quiet_q < 8'h0C)
      else $error("sample valid without bit clock");

   a_taken_on_fall: assert property (sample_taken |-> $fell(bit_clock))
      else $error("sample latched off the bit clock fall");

   c_sample: cover property (sample_valid);
   c_sleep: cover property ($rose(dsp_sleep));
   c_wake: cover property ($fell(amp_hiz));
endmodule

// ---- verif/serial_audio_input_port_test.sv ----
`timescale 1ns/100ps
`include "sai_regs.svh"
module serial_audio_input_port_test;
   localparam int          HALT  = 40;
   localparam logic [11:0] A_FMT = 12'(`SAI_IDX_FORMAT << 2);
   localparam logic [11:0] A_OFF = 12'(`SAI_IDX_OFFSET << 2);
   localparam logic [11:0] A_STA = 12'(`SAI_IDX_STATUS << 2);
   localparam logic [11:0] A_CTL = `SAI_ADDR_CTRL;
   localparam logic [11:0] A_IST = `SAI_ADDR_ISTAT;
   localparam logic [11:0] A_IEN = `SAI_ADDR_IEN;
   localparam logic [11:0] A_ICL = `SAI_ADDR_ICLR;
   localparam logic [1:0]  OK    = `SAI_RESP_OKAY;
   localparam logic [1:0]  ERR   = `SAI_RESP_SLVERR;
   localparam logic [1:0]  C_FMT [5] = '{sai_pkg::SAI_FMT_I2S, sai_pkg::SAI_FMT_LJ,
      sai_pkg::SAI_FMT_RJ, sai_pkg::SAI_FMT_TDM, sai_pkg::SAI_FMT_I2S};
   localparam logic [1:0]  C_WL  [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
   localparam logic [8:0]  C_OFS [5] = '{9'h000, 9'h001, 9'h000, 9'h002, 9'h000};
   localparam logic [9:0]  C_FB  [5] = '{10'h040, 10'h040, 10'h020, 10'h080, 10'h040};

   logic        core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, sample_valid, amp_hiz, dsp_sleep, irq, run, taken;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rate_code, h_fmt, h_wl;
   logic [3:0]  s_axi_wstrb;
   logic [8:0]  h_ofs;
   logic [9:0]  h_fb;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, left_sample, right_sample, h_left, h_right;
   int          n_mismatch, checked, k;

   ////////////////////////////////////////////////////////////////////////////////
   // Both ends and the checker
   sai_link_if sai_link_if_inst ();

   sai_host sai_host_inst
   (
      .core_clk, .resetn, .link(sai_link_if_inst), .fmt(h_fmt), .wl_code(h_wl),
      .offset(h_ofs), .frame_bits(h_fb), .run, .left_in(h_left), .right_in(h_right),
      .sample_taken(taken)
   );

   sai_device #(.HALT_CYC(HALT)) sai_device_inst
   (
      .core_clk, .resetn, .link(sai_link_if_inst), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .left_sample, .right_sample, .sample_valid, .rate_code, .amp_hiz, .dsp_sleep, .irq
   );

   sai_link_props #(.HALT_CYC(HALT)) sai_link_props_inst
   (
      .core_clk, .resetn, .bit_clock(sai_link_if_inst.bit_clock),
      .word_clock_frame_sync(sai_link_if_inst.word_clock_frame_sync),
      .serial_audio_data_in(sai_link_if_inst.serial_audio_data_in),
      .sample_valid, .amp_hiz, .dsp_sleep, .sample_taken(taken)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bail(input string nm);
      n_mismatch++;
      $display("ERROR %s expected answer seen timeout", nm);
      print_verdict();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus and link tasks
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      if (n >= 100)
         bail("bvalid");
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic [1:0] er, input string nm);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      if (n >= 100)
         bail(nm);
      chk(nm, e, s_axi_rdata & m);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   task automatic halt_link();
      @(posedge core_clk);
      run <= 1'b0;
      repeat (1000) @(posedge core_clk);
      chk("halt_hiz", 32'h1, {31'h0, amp_hiz});
      chk("halt_sleep", 32'h1, {31'h0, dsp_sleep});
      axi_rd(A_STA, 32'h3, 32'h3, OK, "halt_status");
   endtask

   task automatic wait_valid(input int cnt);
      int n;
      n = 0;
      repeat (cnt)
      begin
         do
         begin
            @(negedge core_clk);
            n++;
         end
         while (sample_valid !== 1'b1 && n < 20000);
      end
      if (n >= 20000)
         bail("sample_valid");
   endtask

   task automatic run_case(input int i);
      logic [31:0] msk;
      logic [31:0] l;
      msk = (C_WL[i] == 2'h3) ? 32'hFFFF_FFFF : 32'hFFFF_FFFF << (5'h10 - {C_WL[i], 2'h0});
      l = (32'h9E37_79B9 + 32'(i) * 32'h0111_1111) & msk;
      halt_link();
      axi_wr(A_FMT, {24'h0, C_OFS[i][8], 1'b0, C_FMT[i],
             (C_FMT[i] == sai_pkg::SAI_FMT_TDM) ? 2'b01 : 2'b00, C_WL[i]}, OK);
      axi_wr(A_OFF, {24'h0, C_OFS[i][7:0]}, OK);
      @(posedge core_clk);
      h_fmt   <= C_FMT[i];
      h_wl    <= C_WL[i];
      h_ofs   <= C_OFS[i];
      h_fb    <= C_FB[i];
      h_left  <= l;
      h_right <= ~l & msk;
      run     <= 1'b1;
      wait_valid(4);
      chk("left", l, left_sample);
      chk("right", ~l & msk, right_sample);
      chk("rate", (C_FB[i] == 10'h020) ? 32'h1 : 32'h0, {30'h0, rate_code});
      chk("play_hiz", 32'h0, {31'h0, amp_hiz});
      axi_rd(A_STA, 32'h0, 32'h3, OK, "run_status");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {run, h_fmt, h_wl, h_ofs, h_fb, h_left, h_right} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      n_mismatch = 0;
      checked = 0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("reset_hiz", 32'h1, {31'h0, amp_hiz});
      axi_rd(A_FMT, 32'h02, 32'hFFFF_FFFF, OK, "format_reset");
      axi_rd(A_OFF, 32'h00, 32'hFFFF_FFFF, OK, "offset_reset");
      axi_rd(A_CTL, 32'h01, 32'hFFFF_FFFF, OK, "ctrl_reset");
      axi_rd(A_IEN, 32'h00, 32'hFFFF_FFFF, OK, "ien_reset");
      axi_rd(A_ICL, 32'h00, 32'hFFFF_FFFF, OK, "iclr_read");
      axi_rd(12'h100, 32'h00, 32'hFFFF_FFFF, ERR, "unmapped");
      axi_wr(A_STA, 32'h01, ERR);
      axi_wr(A_IST, 32'h07, ERR);
      axi_wr(A_FMT, 32'hFFFF_FFB6, OK);
      axi_rd(A_FMT, 32'hB6, 32'hFFFF_FFFF, OK, "format_rw");
      for (k = 0; k < 5; k++)
         run_case(k);
      axi_wr(A_CTL, 32'h0, OK);
      repeat (3) @(negedge core_clk);
      chk("stop_hiz", 32'h1, {31'h0, amp_hiz});
      axi_wr(A_CTL, 32'h1, OK);
      axi_wr(A_ICL, 32'h7, OK);
      axi_wr(A_IEN, 32'h1, OK);
      halt_link();
      axi_wr(A_FMT, 32'h02, OK);
      @(posedge core_clk);
      h_fmt <= sai_pkg::SAI_FMT_I2S;
      h_wl  <= 2'h2;
      h_fb  <= 10'h080;
      run   <= 1'b1;
      k = 0;
      do
      begin
         @(negedge core_clk);
         k++;
      end
      while (irq !== 1'b1 && k < 20000);
      chk("irq_raised", 32'h1, {31'h0, irq});
      axi_rd(A_STA, 32'h1, 32'h1, OK, "ratio_status");
      axi_rd(A_IST, 32'h1, 32'h1, OK, "ratio_event");
      axi_wr(A_IEN, 32'h0, OK);
      repeat (2) @(negedge core_clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      axi_wr(A_ICL, 32'h1, OK);
      axi_rd(A_IST, 32'h0, 32'h1, OK, "event_cleared");
      print_verdict();
   end
endmodule
